/* monitor_pin_control_tb_top.sv */
`timescale 1ns/10ps
module monitor_pin_control_tb_top;
	logic core_clk = 0, reset = 1, a0s = 0, a1 = 0, ten = 0, intrude = 0;
	logic ext_n = 1, ack = 0;
	logic [7:0] tin = 0, dset = 0, cfg = 0;
	logic [15:0] viol = 0, sclr = 0, mask = 0;
	logic [4:0] vid = 0;
	wire [7:0] dcode, vs, v4;
	wire [15:0] ist;
	wire [6:0] sa;
	wire a0_o, a0_oe, dact, chs_i, chs_oe, seen, int_oe, rst_i, rst_oe, rrst;
	wire a0_i = a0_oe ? a0_o : a0s;
	int error_cnt = 0, tests_run = 0;
	always #4 core_clk = ~core_clk;
	mpc_pin_ctrl #(.PULSE_CYC(10), .DEB_CYC(4)) u_mpc_pin_ctrl (.core_clk,
		.reset, .addr_bit0_tree_out_i(a0_i), .addr_bit0_tree_out_o(a0_o),
		.addr_bit0_tree_out_oe(a0_oe), .addr_bit1_strap(a1),
		.dac_out_tree_enable(ten), .tree_inputs(tin), .dac_setting(dset),
		.dac_code(dcode), .dac_active(dact), .intrusion_line_i(chs_i),
		.intrusion_line_o(), .intrusion_line_oe(chs_oe), .intrusion_seen(seen),
		.intrusion_ack(ack), .config_bits(cfg), .limit_violation(viol),
		.status_clear(sclr), .int_mask(mask), .int_status(ist), .int_n_o(),
		.int_n_oe(int_oe), .master_reset_n_i(rst_i), .master_reset_n_o(),
		.master_reset_n_oe(rst_oe), .remote_reset(rrst),
		.cpu_voltage_id_pins(vid), .vid_status(vs), .vid4_status(v4),
		.slave_address(sa));
	mpc_board u_mpc_board (.intrude, .chs_oe, .rst_oe, .ext_rst_n(ext_n),
		.chs_i, .rst_i);
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task test_done;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task t_pins;
		for (int i = 0; i < 4; i++)
		begin
			{a1, a0s} = i[1:0];
			vid = 5'h13 ^ i[4:0];
			dset = 8'h3c + i[7:0];
			cyc(2);
			chk("addr", {5'h0b, a1, a0s}, sa);
			chk("vid", {4'h5, vid[3:0]}, vs);
			chk("vid4", {7'h40, vid[4]}, v4);
			chk("dac", dset, dcode);
		end
		ten = 1;
		tin = 8'hff;
		cyc(1);
		chk("tree lo", 0, a0_i);
		chk("addr hold", {5'h0b, 2'b11}, sa);
		chk("dac act", 0, dact);
		tin = 8'h7f;
		cyc(1);
		chk("tree hi", 1, a0_i);
		ten = 0;
		$display("pins done");
	endtask
	task t_pulse;
		intrude = 1;
		cyc(2);
		chk("seen", 1, seen);
		intrude = 0;
		cfg = 8'h50;
		cyc(1);
		chk("pulses", 3, {chs_oe, rst_oe});
		chk("cleared", 0, chs_i);
		cfg = 0;
		cyc(1);
		cfg = 8'h50;
		cyc(8);
		chk("held", 3, {chs_oe, rst_oe});
		chk("no self reset", 0, rrst);
		cyc(1);
		chk("ended", 0, {chs_oe, rst_oe});
		ack = 1;
		cfg = 0;
		cyc(1);
		ack = 0;
		chk("ack", 0, seen);
		$display("pulse done");
	endtask
	task t_int;
		viol = 16'h0008;
		cyc(1);
		viol = 0;
		cyc(1);
		chk("status", 16'h0008, ist);
		chk("int off", 0, int_oe);
		cfg = 8'h02;
		cyc(2);
		chk("int on", 1, int_oe);
		mask = 16'h0008;
		cyc(2);
		chk("masked", 0, int_oe);
		sclr = 16'hffff;
		cyc(1);
		sclr = 0;
		mask = 0;
		cyc(1);
		chk("clr", 0, {ist[14:0], int_oe});
		viol = 16'h8001;
		sclr = 16'h8001;
		cyc(1);
		viol = 0;
		sclr = 0;
		chk("set wins", 16'h8001, ist);
		cfg = 0;
		$display("int done");
	endtask
	task t_remote;
		ext_n = 0;
		cyc(3);
		chk("debounce", 0, rrst);
		cyc(5);
		chk("remote", 1, rrst);
		chk("default", 8'hff, dcode);
		chk("status default", 16'h0000, ist);
		ext_n = 1;
		cyc(4);
		chk("resume", {rrst, dset}, {1'b0, dcode});
		$display("remote done");
	endtask
	initial
	begin
		cyc(2);
		reset = 0;
		t_pins();
		t_pulse();
		t_int();
		t_remote();
		test_done();
	end
	initial
	begin
		#20000;
		error_cnt++;
		test_done();
	end
endmodule

/* mpc_board.sv */
`timescale 1ns/10ps
module mpc_board
(
	input wire logic intrude,
	input wire logic chs_oe,
	input wire logic rst_oe,
	input wire logic ext_rst_n,
	output logic chs_i,
	output logic rst_i
);
	logic latch_reg = 1'b0;
	// Outside latch holds its event until the device pulls it low
	always @(posedge intrude or posedge chs_oe)
		latch_reg <= !chs_oe;
	assign chs_i = latch_reg && !chs_oe;
	assign rst_i = !rst_oe && ext_rst_n;
endmodule

/* mpc_params.svh */
// Function
// - First address strap pin is the low programmable slave address bit.
// - Second address strap pin is the high programmable slave address bit.
// - In tree test mode the first strap pin drives the tree result.
// - High test-enable input selects tree test; otherwise pin is DAC output.
// - High intrusion line is an event; config bit 6 clears it 20 ms low.
// - Interrupt output drives low only when config bit 1 set; off at reset.
// - Config bit 4 makes reset pin pulse low at least 20 ms.
// - External low on reset pin resets the device.
// - Reset request is debounced and delayed, then state returns to defaults.
// - Five voltage-ID pins readable in two status registers.
// - Interrupt can fire when any monitored quantity leaves range.
// - Fan control output set by an 8-bit converter value.
// - Slave address is 01011 followed by the two strap levels.
// - Limit violation sets the matching interrupt status flag.
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH
`define MPC_CLK_MHZ 125
`define MPC_PULSE_MS 20
`define MPC_PULSE_CYC (`MPC_PULSE_MS * 1000 * `MPC_CLK_MHZ)
`define MPC_DEB_CYC 1024
`define MPC_CFG_INT_EN 1
`define MPC_CFG_RST_EN 4
`define MPC_CFG_CHS_CLR 6
`define MPC_ADDR_HI 5'h0b
`define MPC_DAC_RESET 8'hff
`define MPC_VID_HI 4'h5
`define MPC_VID4_HI 7'h40
`endif

/* mpc_pin_ctrl.sv */
`timescale 1ns/10ps
`include "mpc_params.svh"
module mpc_pin_ctrl
	import mpc_pkg::*;
#(
	parameter int unsigned PULSE_CYC = `MPC_PULSE_CYC,
	parameter int unsigned DEB_CYC = `MPC_DEB_CYC
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic addr_bit0_tree_out_i,
	output logic addr_bit0_tree_out_o,
	output logic addr_bit0_tree_out_oe,
	input wire logic addr_bit1_strap,
	input wire logic dac_out_tree_enable,
	input wire logic [7:0] tree_inputs,
	input wire logic [7:0] dac_setting,
	output logic [7:0] dac_code,
	output logic dac_active,
	input wire logic intrusion_line_i,
	output logic intrusion_line_o,
	output logic intrusion_line_oe,
	output logic intrusion_seen,
	input wire logic intrusion_ack,
	input wire logic [7:0] config_bits,
	input wire logic [15:0] limit_violation,
	input wire logic [15:0] status_clear,
	input wire logic [15:0] int_mask,
	output logic [15:0] int_status,
	output logic int_n_o,
	output logic int_n_oe,
	input wire logic master_reset_n_i,
	output logic master_reset_n_o,
	output logic master_reset_n_oe,
	output logic remote_reset,
	input wire logic [4:0] cpu_voltage_id_pins,
	output logic [7:0] vid_status,
	output logic [7:0] vid4_status,
	output logic [6:0] slave_address
);
	logic [6:0] slave_address_next;
	logic tree_result;
	logic int_any;
	logic chs_busy;
	logic rst_busy;
	logic chs_go;
	logic rst_go;
	logic ext_low;
	logic [15:0] status_next;
	logic [10:0] deb_reg;
	logic rrst_reg;
	logic soft_rst;
	logic [7:0] cfg_prev_reg;
	logic intr_reg;
	logic intr_next;
	logic addr_lo_next;
	logic deb_full;
	logic [10:0] deb_next;
	logic rrst_next;
	logic [7:0] vid_next;
	logic [7:0] vid4_next;
	logic int_enable;

	// Remote reset folds into the async reset of everything except deb_reg and rrst_reg
	assign soft_rst = reset | rrst_reg;
	// Strap is an output in tree test, so its address bit is held
	assign addr_lo_next = dac_out_tree_enable ? slave_address[0]
		: addr_bit0_tree_out_i;
	assign slave_address_next = {`MPC_ADDR_HI, addr_bit1_strap,
		addr_lo_next};
	assign tree_result = ~&tree_inputs;
	assign addr_bit0_tree_out_o = tree_result;
	assign addr_bit0_tree_out_oe = dac_out_tree_enable;
	assign dac_active = ~dac_out_tree_enable;
	assign chs_go = config_bits[`MPC_CFG_CHS_CLR]
		& ~cfg_prev_reg[`MPC_CFG_CHS_CLR];
	assign rst_go = config_bits[`MPC_CFG_RST_EN]
		& ~cfg_prev_reg[`MPC_CFG_RST_EN];
	assign intrusion_line_o = 1'b0;
	assign intrusion_line_oe = chs_busy;
	assign master_reset_n_o = 1'b0;
	assign master_reset_n_oe = rst_busy;
	// Own drive must not trigger our own reset
	assign ext_low = ~master_reset_n_i & ~rst_busy;
	assign int_any = |(int_status & ~int_mask);
	assign int_n_o = 1'b0;
	assign int_enable = config_bits[`MPC_CFG_INT_EN];
	assign int_n_oe = int_any & int_enable;
	// Set beats clear in the same cycle
	assign status_next = (int_status & ~status_clear) | limit_violation;
	assign remote_reset = rrst_reg;
	assign deb_full = (deb_reg == DEB_CYC[10:0]);
	// Any high sample restarts the count, which is the debounce
	assign deb_next = !ext_low ? 11'h000
		: deb_full ? deb_reg : deb_reg + 11'h001;
	assign rrst_next = ext_low & deb_full;
	assign intr_next = (intr_reg & ~intrusion_ack)
		| (intrusion_line_i & ~chs_busy);
	assign vid_next = {`MPC_VID_HI,
		cpu_voltage_id_pins[3:0]};
	assign vid4_next = {`MPC_VID4_HI,
		cpu_voltage_id_pins[4]};

	mpc_pulse #(.CYCLES(PULSE_CYC)) u_chs_pulse
	(
		.core_clk(core_clk),
		.reset(soft_rst),
		.start(chs_go),
		.busy(chs_busy)
	);

	mpc_pulse #(.CYCLES(PULSE_CYC)) u_rst_pulse
	(
		.core_clk(core_clk),
		.reset(soft_rst),
		.start(rst_go),
		.busy(rst_busy)
	);

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			deb_reg <= 11'h000;
		end
		else
		begin
			deb_reg <= deb_next;
		end
	end

	// Only the pin reset clears this, or it would release itself
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rrst_reg <= 1'b0;
		end
		else
		begin
			rrst_reg <= rrst_next;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			cfg_prev_reg <= 8'h00;
		end
		else
		begin
			cfg_prev_reg <= config_bits;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			int_status <= 16'h0000;
		end
		else
		begin
			int_status <= status_next;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			intr_reg <= 1'b0;
		end
		else
		begin
			intr_reg <= intr_next;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			dac_code <= `MPC_DAC_RESET;
		end
		else
		begin
			dac_code <= dac_setting;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			vid_status <= 8'h00;
		end
		else
		begin
			vid_status <= vid_next;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			vid4_status <= 8'h00;
		end
		else
		begin
			vid4_status <= vid4_next;
		end
	end

	always_ff @(posedge core_clk or posedge soft_rst)
	begin
		if (soft_rst)
		begin
			slave_address <= 7'h00;
		end
		else
		begin
			slave_address <= slave_address_next;
		end
	end

	assign intrusion_seen = intr_reg;
endmodule

/* mpc_pin_ctrl_asserts.sv */
`timescale 1ns/10ps
module mpc_pin_ctrl_asserts #(parameter int unsigned PULSE_CYC = 10)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic addr_bit0_tree_out_i,
	input wire logic addr_bit0_tree_out_o,
	input wire logic addr_bit0_tree_out_oe,
	input wire logic addr_bit1_strap,
	input wire logic dac_out_tree_enable,
	input wire logic [7:0] tree_inputs,
	input wire logic dac_active,
	input wire logic intrusion_line_oe,
	input wire logic [7:0] config_bits,
	input wire logic int_n_oe,
	input wire logic master_reset_n_oe,
	input wire logic remote_reset,
	input wire logic [6:0] slave_address
);
	logic [31:0] c6_reg;
	logic [31:0] c4_reg;
	wire up = !reset && !remote_reset;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset || remote_reset);
	// High-time counters; oe is low in reset so they settle
	always_ff @(posedge core_clk)
	begin
		c6_reg <= intrusion_line_oe ? c6_reg + 32'h1 : 32'h0;
		c4_reg <= master_reset_n_oe ? c4_reg + 32'h1 : 32'h0;
	end
	AST_ADDR_LO: assert property ($past(up && !dac_out_tree_enable) |->
		slave_address[0] == $past(addr_bit0_tree_out_i)) else $error("a0 bad");
	AST_ADDR_HOLD: assert property ($past(up && dac_out_tree_enable) |->
		slave_address[0] == $past(slave_address[0]))
		else $error("a0 sampled in tree test");
	AST_ADDR_HI: assert property ($past(up) |->
		slave_address[1] == $past(addr_bit1_strap)) else $error("a1 bad");
	AST_ADDR_TOP: assert property ($past(up) |->
		slave_address[6:2] == 5'h0b) else $error("address top bad");
	AST_TREE: assert property (dac_out_tree_enable |->
		addr_bit0_tree_out_oe && addr_bit0_tree_out_o == ~&tree_inputs)
		else $error("tree output bad");
	AST_DAC: assert property (dac_active != dac_out_tree_enable)
		else $error("dac mode bad");
	AST_CHS: assert property ($fell(intrusion_line_oe) |->
		c6_reg == PULSE_CYC) else $error("clear pulse width bad");
	AST_RSTN: assert property ($fell(master_reset_n_oe) |->
		c4_reg == PULSE_CYC) else $error("reset pulse width bad");
	AST_INT: assert property (!config_bits[1] && $past(!config_bits[1])
		|-> !int_n_oe) else $error("interrupt drove while off");
	cover property ($rose(intrusion_line_oe));
	cover property ($rose(master_reset_n_oe));
	cover property ($rose(int_n_oe));
	cover property ($rose(addr_bit0_tree_out_oe));
endmodule
bind mpc_pin_ctrl mpc_pin_ctrl_asserts #(.PULSE_CYC(PULSE_CYC)) u_chk (.*);

/* mpc_pkg.sv */
package mpc_pkg;
	typedef enum logic [1:0] {MPC_IDLE, MPC_LOW} mpc_pulse_st_t;
endpackage

/* mpc_pulse.sv */
`timescale 1ns/10ps
`include "mpc_params.svh"
module mpc_pulse
	import mpc_pkg::*;
#(
	parameter int unsigned CYCLES = `MPC_PULSE_CYC
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic start,
	output logic busy
);
	mpc_pulse_st_t state_reg;
	logic [31:0] count_reg;
	logic done;
	assign done = (count_reg == 32'h00000001);
	assign busy = (state_reg == MPC_LOW);
	// Once started, runs to the end regardless of start
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= MPC_IDLE;
			count_reg <= 32'h00000000;
		end
		else
		begin
			case (state_reg)
				MPC_IDLE:
				begin
					if (start)
					begin
						state_reg <= MPC_LOW;
						count_reg <= CYCLES;
					end
				end
				MPC_LOW:
				begin
					count_reg <= count_reg - 32'h00000001;
					if (done)
						state_reg <= MPC_IDLE;
				end
				default:
					state_reg <= MPC_IDLE;
			endcase
		end
	end
endmodule
